// ---- rtl/ppg_defs.svh ----
// Constants of the pulse position profile generator
`ifndef PPG_DEFS_SVH
`define PPG_DEFS_SVH

// ==========================================
// Timing
`define PPG_CLK_MHZ       40
`define PPG_CLK_HZ        27'd40000000
`define PPG_RAMP_US       4000
`define PPG_RAMP_CYC      (`PPG_RAMP_US * `PPG_CLK_MHZ)
`define PPG_PULSE_NS      500
`define PPG_PULSE_CYC     5'((`PPG_PULSE_NS * `PPG_CLK_MHZ) / 1000)
`define PPG_TICKS_PER_SEC (1000000 / `PPG_RAMP_US)

// ==========================================
// Profile arithmetic
`define PPG_MIN_FREQ      20'h00064
`define PPG_ONE           17'h10000
`define PPG_FRAC          16

// ==========================================
// Register byte addresses
`define PPG_A_CTRL        8'h00
`define PPG_A_CFG         8'h04
`define PPG_A_TGT         8'h08
`define PPG_A_START       8'h0c
`define PPG_A_ACC         8'h10
`define PPG_A_DEC         8'h14
`define PPG_A_CNT         8'h18
`define PPG_A_PVSET       8'h1c
`define PPG_A_PV          8'h20
`define PPG_A_STAT        8'h24
`define PPG_A_IRQ_STAT    8'h28
`define PPG_A_IRQ_MASK    8'h2c

// ==========================================
// Field positions
`define PPG_CTRL_POS      0
`define PPG_CTRL_JOG      1
`define PPG_CTRL_STOP     2
`define PPG_CTRL_PVSET    3
`define PPG_CFG_SCURVE    0
`define PPG_CFG_ABS       1
`define PPG_CFG_CCW       2
`define PPG_CFG_PVRST     3
`define PPG_IRQ_DONE      0
`define PPG_IRQ_ERR       1

`endif

// ---- rtl/ppg_pkg.sv ----
// Types of the pulse position profile generator
package ppg_pkg;

    typedef enum logic [3:0] {
        PPG_IDLE   = 4'b0001,
        PPG_ACCEL  = 4'b0010,
        PPG_CRUISE = 4'b0100,
        PPG_DECEL  = 4'b1000
    } ppg_state_e;

    typedef struct packed {
        ppg_state_e   st;
        logic [3:0]   cfg;
        logic [19:0]  tgt_freq;
        logic [19:0]  start_freq;
        logic [15:0]  acc_rate;
        logic [15:0]  dec_rate;
        logic [31:0]  cnt;
        logic [31:0]  pv_set;
        logic [31:0]  pv;
        logic         origin_def;
        logic         jog;
        logic         halt;
        logic         shape_s;
        logic [19:0]  fs;
        logic [19:0]  span;
        logic [16:0]  x;
        logic [31:0]  remaining;
        logic [17:0]  tick_cnt;
        logic [4:0]   pw_cnt;
        logic         pvrst_q;
        logic [1:0]   irq_stat;
        logic [1:0]   irq_mask;
        logic         pulse_out;
        logic         dir_out;
        logic         irq;
        logic [31:0]  rdata;
    } ppg_state_s;

    typedef struct packed {
        logic [26:0]  acc;
        logic         step;
    } ppg_rate_s;

endpackage

// ---- rtl/ppg_rate_gen.sv ----
// Phase accumulator turning a frequency in pps into step strobes
`timescale 1ns/1ps
`include "ppg_defs.svh"

module ppg_rate_gen
    import ppg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [19:0] freq,
    output logic             step
);

    ppg_rate_s r_reg;
    ppg_rate_s r_next;
    logic [26:0] sum;

    // ==========================================
    // Accumulator
    always_comb
    begin
        r_next = r_reg;
        sum    = r_reg.acc + 27'(freq);
        r_next.step = 1'b0;
        if (!run)
        begin
            // Phase restarts so the first pulse of a move is not early
            r_next.acc = '0;
        end
        else if (sum >= `PPG_CLK_HZ)
        begin
            r_next.acc  = sum - `PPG_CLK_HZ;
            r_next.step = 1'b1;
        end
        else
        begin
            r_next.acc = sum;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign step = r_reg.step;

endmodule // ppg_rate_gen

// ---- rtl/ppg_top.sv ----
// Pulse position profile generator: one channel with register port
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "ppg_defs.svh"

module ppg_top
    import ppg_pkg::*;
#(
    parameter int RAMP_CYCLES = `PPG_RAMP_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic        origin_search_done,
    output logic [31:0]      rdata,
    output logic             pulse_out,
    output logic             dir_out,
    output logic             irq
);

    ppg_state_s s_reg;
    ppg_state_s s_next;
    logic       step;
    logic [19:0] f_now;
    logic        busy;

    // Braking distance follows the real tick length, short test ticks too
    localparam int TICKS_PER_SEC = int'(`PPG_CLK_HZ / RAMP_CYCLES);

    // Smoothstep 3x^2 - 2x^3 keeps the area of the linear ramp
    function automatic logic [16:0] ppg_shape(input logic [16:0] x, input logic sc);
        logic [33:0] x2;
        logic [33:0] x3;
        logic [19:0] p;
        x2 = 34'(x) * 34'(x);
        x3 = 34'(x2[32:16]) * 34'(x);
        p  = 20'(3 * 20'(x2[32:16])) - 20'(2 * 20'(x3[32:16]));
        if (sc)
            ppg_shape = p[16:0];
        else
            ppg_shape = x;
    endfunction

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ref_a);
        wr_hit = (a == ref_a);
    endfunction

    // ==========================================
    // Present frequency from ramp position
    logic [36:0] prod;
    always_comb
    begin
        prod  = 37'(s_reg.span) * 37'(ppg_shape(s_reg.x, s_reg.shape_s));
        f_now = s_reg.fs + prod[35:16];
    end

    assign busy = (s_reg.st != PPG_IDLE);

    ppg_rate_gen u_rate (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (busy),
        .freq    (f_now),
        .step    (step)
    );

    // ==========================================
    // Next state
    logic [15:0]        rate_sel;
    logic [31:0]        quot;
    logic [16:0]        stp;
    logic [17:0]        x_sum;
    logic               sc_eff;
    logic [19:0]        fs_eff;
    logic signed [32:0] diff;
    logic [63:0]        lhs;
    logic [39:0]        rhs;
    logic               tick;
    logic               do_pos;
    logic               do_jog;
    logic               do_stop;

    always_comb
    begin
        s_next  = s_reg;
        do_pos  = wr && wr_hit(addr, `PPG_A_CTRL) && wdata[`PPG_CTRL_POS];
        do_jog  = wr && wr_hit(addr, `PPG_A_CTRL) && wdata[`PPG_CTRL_JOG];
        do_stop = wr && wr_hit(addr, `PPG_A_CTRL) && wdata[`PPG_CTRL_STOP];
        sc_eff  = s_reg.cfg[`PPG_CFG_SCURVE] && (s_reg.tgt_freq >= `PPG_MIN_FREQ);
        if (sc_eff)
            fs_eff = `PPG_MIN_FREQ;
        else if (s_reg.start_freq < `PPG_MIN_FREQ)
            fs_eff = `PPG_MIN_FREQ;
        else
            fs_eff = s_reg.start_freq;
        diff    = $signed({s_reg.cnt[31], s_reg.cnt}) - $signed({s_reg.pv[31], s_reg.pv});
        rate_sel = (s_reg.st == PPG_DECEL && !s_reg.jog) ? s_reg.dec_rate : s_reg.acc_rate;
        // Division by the span; a zero span ramps in one tick
        quot    = {rate_sel, 16'h0000} / ((s_reg.span == 20'h00000) ? 32'h1 : 32'(s_reg.span));
        stp     = (quot > 32'(`PPG_ONE)) ? `PPG_ONE : quot[16:0];
        x_sum   = 18'(s_reg.x) + 18'(stp);
        tick    = (s_reg.tick_cnt == 18'(RAMP_CYCLES - 1));
        lhs     = 64'(s_reg.remaining) * 64'(s_reg.dec_rate) * 64'(2 * TICKS_PER_SEC);
        rhs     = 40'(f_now) * 40'(f_now) - 40'(s_reg.fs) * 40'(s_reg.fs);

        // ==========================================
        // Register writes and reads
        s_next.rdata = '0;
        if (wr)
        begin
            case (addr)
                `PPG_A_CFG:      s_next.cfg        = wdata[3:0];
                `PPG_A_TGT:      s_next.tgt_freq   = wdata[19:0];
                `PPG_A_START:    s_next.start_freq = wdata[19:0];
                `PPG_A_ACC:      s_next.acc_rate   = wdata[15:0];
                `PPG_A_DEC:      s_next.dec_rate   = wdata[15:0];
                `PPG_A_CNT:      s_next.cnt        = wdata;
                `PPG_A_PVSET:    s_next.pv_set     = wdata;
                `PPG_A_IRQ_STAT: s_next.irq_stat   = s_reg.irq_stat & ~wdata[1:0];
                `PPG_A_IRQ_MASK: s_next.irq_mask   = wdata[1:0];
                default:         s_next.cfg        = s_reg.cfg;
            endcase
        end
        if (rd)
        begin
            case (addr)
                `PPG_A_CFG:      s_next.rdata = {28'h0000000, s_reg.cfg};
                `PPG_A_TGT:      s_next.rdata = {12'h000, s_reg.tgt_freq};
                `PPG_A_START:    s_next.rdata = {12'h000, s_reg.start_freq};
                `PPG_A_ACC:      s_next.rdata = {16'h0000, s_reg.acc_rate};
                `PPG_A_DEC:      s_next.rdata = {16'h0000, s_reg.dec_rate};
                `PPG_A_CNT:      s_next.rdata = s_reg.cnt;
                `PPG_A_PVSET:    s_next.rdata = s_reg.pv_set;
                `PPG_A_PV:       s_next.rdata = s_reg.pv;
                // Absolute coordinates exactly while the origin is defined
                `PPG_A_STAT:     s_next.rdata = {20'h00000, s_reg.st, 4'h0, s_reg.dir_out,
                                                 s_reg.jog, s_reg.origin_def, busy};
                `PPG_A_IRQ_STAT: s_next.rdata = {30'h00000000, s_reg.irq_stat};
                `PPG_A_IRQ_MASK: s_next.rdata = {30'h00000000, s_reg.irq_mask};
                default:         s_next.rdata = '0;
            endcase
        end

        // ==========================================
        // Origin and present value
        s_next.pvrst_q = s_reg.cfg[`PPG_CFG_PVRST];
        if (wr && wr_hit(addr, `PPG_A_CTRL) && wdata[`PPG_CTRL_PVSET])
        begin
            s_next.pv         = s_reg.pv_set;
            s_next.origin_def = 1'b1;
        end
        if (s_reg.cfg[`PPG_CFG_PVRST] && !s_reg.pvrst_q)
        begin
            s_next.origin_def = 1'b0;
            if (!busy)
                s_next.pv = '0;
        end
        // Search completion beats a reset bit edge in the same cycle
        if (origin_search_done)
            s_next.origin_def = 1'b1;

        // ==========================================
        // Ramp tick
        if (!busy || tick)
            s_next.tick_cnt = '0;
        else
            s_next.tick_cnt = s_reg.tick_cnt + 18'h00001;

        // ==========================================
        // Motion
        case (s_reg.st)
            PPG_IDLE:
            begin
                if (do_pos && s_reg.cfg[`PPG_CFG_ABS] && !s_reg.origin_def)
                begin
                    s_next.irq_stat[`PPG_IRQ_ERR] = 1'b1;
                end
                else if (do_pos || do_jog)
                begin
                    s_next.st      = PPG_ACCEL;
                    s_next.jog     = do_jog;
                    s_next.halt    = 1'b0;
                    s_next.shape_s = sc_eff;
                    s_next.fs      = fs_eff;
                    s_next.span    = (s_reg.tgt_freq > fs_eff) ? s_reg.tgt_freq - fs_eff : '0;
                    s_next.x       = '0;
                    if (do_pos && s_reg.cfg[`PPG_CFG_ABS])
                    begin
                        s_next.dir_out   = diff[32];
                        s_next.remaining = diff[32] ? 32'(-diff) : diff[31:0];
                    end
                    else
                    begin
                        s_next.dir_out   = s_reg.cfg[`PPG_CFG_CCW];
                        s_next.remaining = s_reg.cnt;
                        if (do_pos && !s_reg.origin_def)
                            s_next.pv = '0;
                    end
                    if (do_pos && s_reg.cfg[`PPG_CFG_ABS] && diff == '0)
                    begin
                        s_next.st = PPG_IDLE;
                        s_next.irq_stat[`PPG_IRQ_DONE] = 1'b1;
                    end
                end
            end
            PPG_ACCEL, PPG_CRUISE:
            begin
                if (do_pos || do_jog)
                    s_next.irq_stat[`PPG_IRQ_ERR] = 1'b1;
                // Early decel start: distance left at or below ramp-down distance
                if (do_stop || (!s_reg.jog && lhs <= 64'(rhs)))
                begin
                    s_next.st   = PPG_DECEL;
                    s_next.halt = do_stop || s_reg.jog;
                    s_next.span = f_now - s_reg.fs;
                    s_next.x    = `PPG_ONE;
                end
                else if (s_reg.st == PPG_ACCEL && tick)
                begin
                    if (x_sum >= 18'(`PPG_ONE))
                    begin
                        s_next.x  = `PPG_ONE;
                        s_next.st = PPG_CRUISE;
                    end
                    else
                    begin
                        s_next.x = x_sum[16:0];
                    end
                end
            end
            PPG_DECEL:
            begin
                if (do_pos || do_jog)
                    s_next.irq_stat[`PPG_IRQ_ERR] = 1'b1;
                if (do_stop)
                    s_next.halt = 1'b1;
                if (tick)
                    s_next.x = (s_reg.x <= stp) ? '0 : s_reg.x - stp;
                // Halted moves end at start speed, counted moves run out at it
                if (s_reg.halt && s_reg.x == '0)
                begin
                    s_next.st = PPG_IDLE;
                    s_next.irq_stat[`PPG_IRQ_DONE] = 1'b1;
                end
            end
            default:
            begin
                s_next.st = PPG_IDLE;
            end
        endcase

        // ==========================================
        // Pulse emission
        if (s_reg.pw_cnt != '0)
            s_next.pw_cnt = s_reg.pw_cnt - 5'h01;
        if (step && busy && s_next.st != PPG_IDLE && (s_reg.jog || s_reg.remaining != '0))
        begin
            s_next.pw_cnt = `PPG_PULSE_CYC;
            if (s_reg.dir_out)
                s_next.pv = s_next.pv - 32'h00000001;
            else
                s_next.pv = s_next.pv + 32'h00000001;
            if (!s_reg.jog)
            begin
                s_next.remaining = s_reg.remaining - 32'h00000001;
                if (s_reg.remaining == 32'h00000001)
                begin
                    s_next.st = PPG_IDLE;
                    s_next.irq_stat[`PPG_IRQ_DONE] = 1'b1;
                end
            end
        end
        if (busy && !s_reg.jog && s_reg.remaining == '0 && s_next.st != PPG_IDLE)
        begin
            s_next.st = PPG_IDLE;
            s_next.irq_stat[`PPG_IRQ_DONE] = 1'b1;
        end
        s_next.pulse_out = (s_next.pw_cnt != '0);
        s_next.irq       = |(s_next.irq_stat & s_next.irq_mask);
    end

    // ==========================================
    // State register; reset also stands for a mode change
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg    <= '0;
            s_reg.st <= PPG_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rdata     = s_reg.rdata;
    assign pulse_out = s_reg.pulse_out;
    assign dir_out   = s_reg.dir_out;
    assign irq       = s_reg.irq;

endmodule // ppg_top

// ---- verification/ppg_top_sva.sv ----
// Port checker of the pulse position profile generator
`timescale 1ns/1ps

module ppg_top_sva
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        origin_search_done,
    input wire logic [31:0] rdata,
    input wire logic        pulse_out,
    input wire logic        dir_out,
    input wire logic        irq
);
    // ======
    // Helper: cycles the step pulse has stood high
    logic [4:0] hi_cnt_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst || !pulse_out)
            hi_cnt_reg <= 5'h00;
        else
            hi_cnt_reg <= hi_cnt_reg + 5'h01;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ======
    // Assertions
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !pulse_out && !irq && rdata == 32'h0) else $error("outputs active in reset");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    chk_unmapped_read: assert property ($past(rd) && $past(addr) == 8'h40 |-> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_pulse_width: assert property ($fell(pulse_out) |-> hi_cnt_reg == 5'h14)
        else $error("step pulse width wrong");
    chk_pulse_max: assert property (pulse_out |-> hi_cnt_reg < 5'h14)
        else $error("step pulse too long");
    chk_dir_hold: assert property (pulse_out |-> $stable(dir_out))
        else $error("direction moved during pulse");
    chk_mask_gate: assert property (wr && addr == 8'h2c && wdata[1:0] == 2'h0 |-> ##1 !irq)
        else $error("masked interrupt still high");
    chk_origin_flag: assert property (
        origin_search_done ##[1:3] (rd && addr == 8'h24) |=> rdata[1])
        else $error("origin flag not set after search");
endmodule // ppg_top_sva

bind ppg_top ppg_top_sva u_ppg_top_sva (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .origin_search_done(origin_search_done),
    .rdata(rdata), .pulse_out(pulse_out), .dir_out(dir_out), .irq(irq));

// ---- verification/ppg_drive_model.sv ----
// Motor drive model: turns step pulses into a shaft position
`timescale 1ns/1ps

module ppg_drive_model
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        pulse_out,
    input  wire logic        dir_out,
    output logic [31:0]      pos
);
    logic pulse_q;

    // Drive steps on the leading edge only
    always @(posedge ref_clk)
    begin
        pulse_q <= pulse_out;
        if (rst)
            pos <= 32'h0;
        else if (pulse_out && !pulse_q)
            pos <= dir_out ? pos - 32'h1 : pos + 32'h1;
    end
endmodule // ppg_drive_model

// ---- verification/ppg_top_tb.sv ----
// Self-checking testbench of the pulse position profile generator
`timescale 1ns/1ps
`include "ppg_defs.svh"

module ppg_top_tb;
    logic        ref_clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        origin_search_done;
    logic [31:0] rdata;
    logic        pulse_out;
    logic        dir_out;
    logic        irq;
    logic [31:0] pos;
    logic [31:0] seed;
    logic [31:0] p0;
    logic [31:0] d;
    int          i;
    int          n_mismatch;
    int          samples_checked;
    logic [31:0] msk [6] = '{32'hfffff, 32'hfffff, 32'hffff, 32'hffff, '1, '1};

    // Short ramp tick keeps the run brief
    ppg_top #(.RAMP_CYCLES(40)) u_ppg_top (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .origin_search_done(origin_search_done),
        .rdata(rdata), .pulse_out(pulse_out), .dir_out(dir_out), .irq(irq));
    ppg_drive_model u_ppg_drive_model (.ref_clk(ref_clk), .rst(rst),
        .pulse_out(pulse_out), .dir_out(dir_out), .pos(pos));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ======
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        chk(v, exp);
    endtask

    task automatic st_chk(input logic org);
        logic [31:0] v;
        bus_rd(`PPG_A_STAT, v);
        chk({31'h0, v[1]}, {31'h0, org});
    endtask

    // Bounded poll of the busy flag
    task automatic wait_idle;
        logic [31:0] v;
        for (int k = 0; k < 5000; k++)
        begin
            bus_rd(`PPG_A_STAT, v);
            if (v[0] === 1'b0)
                return;
        end
        n_mismatch++;
        wrap_up;
    endtask

    task automatic move(input logic [31:0] cfg, input logic [31:0] cnt,
                        input logic [31:0] pv_exp, input logic [31:0] d_exp);
        bus_wr(`PPG_A_CNT, cnt);
        bus_wr(`PPG_A_CFG, cfg);
        p0 = pos;
        bus_wr(`PPG_A_CTRL, 32'h1);
        wait_idle;
        repeat (20) @(posedge ref_clk);
        rd_chk(`PPG_A_PV, pv_exp);
        chk(pos - p0, d_exp);
        rd_chk(`PPG_A_IRQ_STAT, 32'h1);
        bus_wr(`PPG_A_IRQ_STAT, 32'h3);
    endtask

    // ======
    // Main sequence
    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        origin_search_done = 1'b0;
        seed = 32'd90;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`PPG_A_STAT, 32'h100);
        rd_chk(`PPG_A_PV, 32'h0);
        for (i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            bus_wr(8'h08 + 8'(i * 4), seed);
            rd_chk(8'h08 + 8'(i * 4), seed & msk[i]);
        end
        rd_chk(8'h40, 32'h0);
        bus_wr(`PPG_A_PV, seed);
        rd_chk(`PPG_A_PV, 32'h0);
        bus_wr(`PPG_A_TGT, 32'h30d40);
        bus_wr(`PPG_A_START, 32'h186a0);
        bus_wr(`PPG_A_ACC, 32'hc350);
        bus_wr(`PPG_A_DEC, 32'hc350);
        bus_wr(`PPG_A_IRQ_MASK, 32'h3);
        // Absolute move with no origin is refused
        bus_wr(`PPG_A_CFG, 32'h2);
        bus_wr(`PPG_A_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`PPG_A_IRQ_STAT, 32'h2);
        bus_wr(`PPG_A_IRQ_MASK, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        bus_wr(`PPG_A_IRQ_STAT, 32'h2);
        rd_chk(`PPG_A_IRQ_STAT, 32'h0);
        bus_wr(`PPG_A_IRQ_MASK, 32'h3);
        // Relative moves, linear then S-curve
        seed = xs(seed);
        move(32'h0, 32'h1 + seed % 32'h6, 32'h1 + seed % 32'h6, 32'h1 + seed % 32'h6);
        seed = xs(seed);
        move(32'h4, 32'h1 + seed % 32'h6, -(32'h1 + seed % 32'h6), -(32'h1 + seed % 32'h6));
        move(32'h5, 32'h3, -32'h3, -32'h3);
        // Target below the floor: S-curve off, so no crawl at the floor speed
        bus_wr(`PPG_A_TGT, 32'h32);
        move(32'h1, 32'h2, 32'h2, 32'h2);
        bus_wr(`PPG_A_TGT, 32'h30d40);
        bus_wr(`PPG_A_CFG, 32'h8);
        rd_chk(`PPG_A_PV, 32'h0);
        bus_wr(`PPG_A_CFG, 32'h0);
        // Value change defines the origin
        seed = xs(seed) & 32'h0fffffff;
        bus_wr(`PPG_A_PVSET, seed);
        bus_wr(`PPG_A_CTRL, 32'h8);
        rd_chk(`PPG_A_PV, seed);
        st_chk(1'b1);
        move(32'h0, 32'h2, seed + 32'h2, 32'h2);
        move(32'h2, seed - 32'h3, seed - 32'h3, -32'h5);
        bus_wr(`PPG_A_CFG, 32'h8);
        st_chk(1'b0);
        rd_chk(`PPG_A_PV, 32'h0);
        bus_wr(`PPG_A_CFG, 32'h0);
        @(posedge ref_clk);
        origin_search_done <= 1'b1;
        @(posedge ref_clk);
        origin_search_done <= 1'b0;
        st_chk(1'b1);
        // Ramped jog, then stop
        bus_wr(`PPG_A_CFG, 32'h1);
        p0 = pos;
        bus_wr(`PPG_A_CTRL, 32'h2);
        repeat (600) @(posedge ref_clk);
        bus_wr(`PPG_A_CTRL, 32'h4);
        wait_idle;
        repeat (20) @(posedge ref_clk);
        bus_rd(`PPG_A_PV, d);
        chk(d, pos - p0);
        chk({31'h0, pos != p0}, 32'h1);
        rd_chk(`PPG_A_IRQ_STAT, 32'h1);
        wrap_up;
    end
endmodule // ppg_top_tb
